// File: rtl/three_wire_serial_port.sv
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "three_wire_serial_port_params.svh"

module three_wire_serial_port
	import three_wire_serial_port_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe,
	input wire logic serial_in_pin_i,
	output logic serial_in_pin_o,
	output logic serial_in_pin_oe,
	input wire logic serial_out_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe,
	input wire logic uart_transmit_pin,
	output logic uart_receive_pin,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// bit presented on the out pin for the current shift register contents
	function automatic logic pick_out(input logic [7:0] sr, input logic lsb_first);
		pick_out = lsb_first ? sr[0] : sr[7];
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic lsb_first,
			input logic din);
		shift_in = lsb_first ? {din, sr[7:1]} : {sr[6:0], din};
	endfunction

	function automatic logic [31:0] read_value(input regs_t s, input logic [7:0] a,
			input logic [2:0] pins);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == `OFS_CLOCK_SELECT) begin
			v[7:0] = s.clock_select;
		end else if (a == `OFS_OP_MODE) begin
			v[7:0] = s.op_mode;
			v[`POS_BUSY] = (s.st == ST_RUN);
		end else if (a == `OFS_TX_BUFFER) begin
			v[7:0] = s.tx_last;
		end else if (a == `OFS_SHIFT) begin
			v[7:0] = s.shreg;
		end else if (a == `OFS_PORT_MODE) begin
			v[2:0] = s.port_mode;
		end else if (a == `OFS_PORT_LATCH) begin
			v[2:0] = s.port_latch;
		end else if (a == `OFS_PIN_LEVEL) begin
			v[2:0] = pins;
		end else if (a == `OFS_IRQ_STATUS) begin
			v[1:0] = s.irq_status;
		end else if (a == `OFS_IRQ_MASK) begin
			v[1:0] = s.irq_mask;
		end
		read_value = v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// decoded configuration

	regs_t q;
	regs_t d;

	logic enable;
	logic tx_mode;
	logic lsb_first;
	logic slave;
	logic idle_level;
	logic [6:0] half_m1;
	logic [2:0] pin_levels;

	assign enable = q.op_mode[`POS_ENABLE];
	assign tx_mode = q.op_mode[`POS_TRANSFER_MODE];
	assign lsb_first = q.op_mode[`POS_BIT_ORDER];
	assign slave = (q.clock_select[2:0] == `CLK_SOURCE_EXTERNAL);
	// phase bit 0 keeps the clock idling high, which is also the quiet port level
	assign idle_level = ~q.clock_select[`POS_CLOCK_PHASE];
	// half period of the internal clock is 2^sel cycles of hclk
	assign half_m1 = 7'((8'h01 << q.clock_select[2:0]) - 8'h01);
	assign pin_levels = {serial_out_pin_i, serial_in_pin_i, serial_clock_pin_i};

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic addr_ok;
		logic wr_done;
		logic rd_done;
		logic start_tx;
		logic start_rx;
		logic lead;
		logic trail;
		logic [1:0] irq_set;
		logic [1:0] irq_clr;
		d = q;
		addr_ok = hsel && hready && htrans[1];
		wr_done = q.wr;
		rd_done = q.rd && !q.rd_wait;
		start_tx = 1'b0;
		start_rx = 1'b0;
		lead = 1'b0;
		trail = 1'b0;
		irq_set = 2'b00;
		irq_clr = 2'b00;

		// bus address phase; a read takes one wait cycle so that its data come from
		// a flop after any write just before it has landed
		if (q.rd && q.rd_wait) begin
			d.rd_wait = 1'b0;
			d.rdata = read_value(q, q.addr, pin_levels);
		end else begin
			d.wr = addr_ok && hwrite;
			d.rd = addr_ok && !hwrite;
			d.rd_wait = addr_ok && !hwrite;
			if (addr_ok) begin
				d.addr = haddr[7:0];
			end
		end

		// bus writes, committed in the data phase
		if (wr_done) begin
			if (q.addr == `OFS_CLOCK_SELECT) begin
				d.clock_select = hwdata[7:0];
			end else if (q.addr == `OFS_OP_MODE) begin
				d.op_mode = hwdata[7:0] & 8'hd0;
			end else if (q.addr == `OFS_TX_BUFFER) begin
				d.tx_last = hwdata[7:0];
				if (enable && q.st == ST_RUN) begin
					irq_set[`IRQ_OVERRUN] = 1'b1;
				end else if (enable) begin
					start_tx = 1'b1;
				end
			end else if (q.addr == `OFS_PORT_MODE) begin
				d.port_mode = hwdata[2:0];
			end else if (q.addr == `OFS_PORT_LATCH) begin
				d.port_latch = hwdata[2:0];
			end else if (q.addr == `OFS_IRQ_STATUS) begin
				irq_clr = hwdata[1:0];
			end else if (q.addr == `OFS_IRQ_MASK) begin
				d.irq_mask = hwdata[1:0];
			end
		end

		// a completed read of the shift register arms the next reception
		if (rd_done && q.addr == `OFS_SHIFT && enable && !tx_mode && q.st == ST_IDLE) begin
			start_rx = 1'b1;
		end

		// edge detection: master from its own divider, slave from the sampled pin
		if (q.st == ST_RUN) begin
			if (slave) begin
				d.sck_prev = serial_clock_pin_i;
				lead = (q.sck_prev == idle_level) && (serial_clock_pin_i != idle_level);
				trail = (q.sck_prev != idle_level) && (serial_clock_pin_i == idle_level);
			end else if (q.divcnt >= half_m1) begin
				d.divcnt = 7'h00;
				d.sck = ~q.sck;
				lead = (q.sck == idle_level);
				trail = (q.sck != idle_level);
			end else begin
				d.divcnt = q.divcnt + 7'h01;
			end
		end else begin
			d.sck_prev = serial_clock_pin_i;
			d.sck = idle_level;
			d.divcnt = 7'h00;
		end

		case (q.st)
			ST_IDLE: begin
				if (start_tx || start_rx) begin
					d.st = ST_RUN;
					d.bitcnt = 4'h0;
					if (start_tx) begin
						d.shreg = hwdata[7:0];
					end
				end
			end
			ST_RUN: begin
				if (lead) begin
					d.so = pick_out(q.shreg, lsb_first);
				end
				if (trail) begin
					d.shreg = shift_in(q.shreg, lsb_first, serial_in_pin_i);
					d.bitcnt = q.bitcnt + 4'h1;
					if (q.bitcnt + 4'h1 == `BITS_PER_BYTE) begin
						d.st = ST_IDLE;
						irq_set[`IRQ_DONE] = 1'b1;
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		// dropping the enable aborts any transfer at once
		if (!enable) begin
			d.st = ST_IDLE;
			d.bitcnt = 4'h0;
		end

		// an event in the same cycle as its clear still sets the flag
		d.irq_status = (q.irq_status & ~irq_clr) | irq_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q.clock_select <= `RST_CLOCK_SELECT;
			q.op_mode <= `RST_OP_MODE;
			q.tx_last <= 8'h00;
			q.shreg <= 8'h00;
			q.port_mode <= `RST_PORT_MODE;
			q.port_latch <= `RST_PORT_LATCH;
			q.irq_status <= 2'h0;
			q.irq_mask <= `RST_IRQ_MASK;
			q.st <= ST_IDLE;
			q.bitcnt <= 4'h0;
			q.divcnt <= 7'h00;
			q.sck <= 1'b1;
			q.sck_prev <= 1'b1;
			q.so <= 1'b1;
			q.addr <= 8'h00;
			q.wr <= 1'b0;
			q.rd <= 1'b0;
			q.rd_wait <= 1'b0;
			q.rdata <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus answers and interrupt

	assign hrdata = q.rdata;
	assign hreadyout = !(q.rd && q.rd_wait);
	assign hresp = 1'b0;
	assign irq = |(q.irq_status & q.irq_mask);

	////////////////////////////////////////////////////////////////////////////
	// pin multiplexing
	// port mode 1 means input, so the enable is its inverse; the serial logic only
	// takes the data level and leaves direction to the port registers, so a peer
	// that disagrees on direction shows up as a clash on the wire, not here

	always_comb begin
		// clock pin: master clock gated by the latch, which must hold 1
		serial_clock_pin_oe = ~q.port_mode[`PIN_CLOCK];
		if (enable && !slave) begin
			serial_clock_pin_o = q.sck & q.port_latch[`PIN_CLOCK];
		end else begin
			serial_clock_pin_o = q.port_latch[`PIN_CLOCK];
		end

		// in pin: always a port latch output when set to output; the serial side only listens
		serial_in_pin_oe = ~q.port_mode[`PIN_IN];
		serial_in_pin_o = q.port_latch[`PIN_IN];
		uart_receive_pin = serial_in_pin_i;

		// out pin: serial data merged with a latch that must hold 0
		serial_out_pin_oe = ~q.port_mode[`PIN_OUT];
		if (enable && tx_mode) begin
			serial_out_pin_o = q.so | q.port_latch[`PIN_OUT];
		end else begin
			serial_out_pin_o = q.port_latch[`PIN_OUT] & uart_transmit_pin;
		end
	end

endmodule

// File: rtl/three_wire_serial_port_params.svh
// Behaviour
// - Enable bit 7 of the mode register turns on serial transmit and receive.
// - Enabled and idle, a transmit buffer write starts a transfer; it sends as well as receives only in transfer mode 1.
// - Enabled for receive only, a shift register read starts the next reception.
// - Enable at 0 stops the unit; pins fall back to UART or port use.
// - Transfer mode 0 receives only, out pin free; 1 drives the out pin.
// - Master clock pin output mode 0 latch 1; slave input; out pin 0/0; in pin 1.
// - An in pin stays an untouched port pin; an out pin unused by the mode gives the port latch ANDed with the UART transmit input.
`ifndef THREE_WIRE_SERIAL_PORT_PARAMS_SVH
`define THREE_WIRE_SERIAL_PORT_PARAMS_SVH

`define OFS_CLOCK_SELECT 8'h00
`define OFS_OP_MODE 8'h04
`define OFS_TX_BUFFER 8'h08
`define OFS_SHIFT 8'h0c
`define OFS_PORT_MODE 8'h10
`define OFS_PORT_LATCH 8'h14
`define OFS_PIN_LEVEL 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_IRQ_MASK 8'h20

`define POS_ENABLE 7
`define POS_TRANSFER_MODE 6
`define POS_BIT_ORDER 4
`define POS_BUSY 0
`define POS_CLOCK_PHASE 4
`define CLK_SOURCE_EXTERNAL 3'h7

`define PIN_CLOCK 0
`define PIN_IN 1
`define PIN_OUT 2

`define IRQ_DONE 0
`define IRQ_OVERRUN 1

`define RST_CLOCK_SELECT 8'h00
`define RST_OP_MODE 8'h00
`define RST_PORT_MODE 3'h7
`define RST_PORT_LATCH 3'h0
`define RST_IRQ_MASK 2'h0
`define BITS_PER_BYTE 4'h8

`endif

// File: rtl/three_wire_serial_port_pkg.sv
package three_wire_serial_port_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} xfer_state_t;

	typedef struct packed {
		logic [7:0] clock_select;
		logic [7:0] op_mode;
		logic [7:0] tx_last;
		logic [7:0] shreg;
		logic [2:0] port_mode;
		logic [2:0] port_latch;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		xfer_state_t st;
		logic [3:0] bitcnt;
		logic [6:0] divcnt;
		logic sck;
		logic sck_prev;
		logic so;
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic rd_wait;
		logic [31:0] rdata;
	} regs_t;

endpackage

// File: verification/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
	input wire logic rst_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic lsb,
	input wire logic [7:0] tx_byte,
	output logic sdo,
	output logic [7:0] rx_byte
);
	logic [2:0] cnt;
	// slave side: clock only taken in, idle high
	always @(posedge sck or negedge sck or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0;
			sdo <= 1'b0;
			rx_byte <= 8'h00;
		end else if (!sck) begin
			sdo <= lsb ? tx_byte[cnt] : tx_byte[3'h7 - cnt];
		end else begin
			rx_byte <= lsb ? {sdi, rx_byte[7:1]} : {rx_byte[6:0], sdi};
			// data holds to the next falling edge: a slave samples a cycle after the rise
			cnt <= cnt + 3'h1;
		end
	end
endmodule

// File: verification/three_wire_serial_port_checker.sv
`timescale 1ns/1ps
module three_wire_serial_port_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic serial_clock_pin_oe,
	input wire logic serial_in_pin_oe,
	input wire logic serial_out_pin_oe,
	input wire logic serial_in_pin_i,
	input wire logic uart_receive_pin,
	input wire logic irq
);
	logic take;
	logic wr_q;
	logic rd_q;
	assign take = hsel & hready & htrans[1];
	// marks the data phase, when register writes land and read data loads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			wr_q <= take & hwrite;
			rd_q <= take & ~hwrite;
		end
	end
	////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_take_s;
		take && !hwrite;
	endsequence
	sequence rd_wait_s;
		!hreadyout ##1 hreadyout;
	endsequence
	AST_READ_WAIT: assert property (rd_take_s |=> rd_wait_s)
		else $error("read wait wrong");
	AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	AST_READY_HIGH: assert property (!rd_q |-> hreadyout)
		else $error("stray wait");
	AST_RDATA_HOLD: assert property (!rd_q |=> $stable(hrdata))
		else $error("read data moved");
	AST_CLK_OE_HOLD: assert property (!wr_q |=> $stable(serial_clock_pin_oe))
		else $error("clock pin dir moved");
	AST_DATA_OE_HOLD: assert property (!wr_q |=> $stable({serial_in_pin_oe,
		serial_out_pin_oe}))
		else $error("data pin dir moved");
	AST_RX_COPY: assert property (uart_receive_pin == serial_in_pin_i)
		else $error("uart rx not fed");
	AST_IRQ_HOLD: assert property (!wr_q |=> !$fell(irq))
		else $error("irq dropped alone");
endmodule
bind three_wire_serial_port three_wire_serial_port_checker chk_u (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .serial_clock_pin_oe(serial_clock_pin_oe),
	.serial_in_pin_oe(serial_in_pin_oe), .serial_out_pin_oe(serial_out_pin_oe),
	.serial_in_pin_i(serial_in_pin_i), .uart_receive_pin(uart_receive_pin), .irq(irq));

// File: verification/three_wire_serial_port_tb.sv
`timescale 1ns/1ps
`include "three_wire_serial_port_params.svh"
module three_wire_serial_port_tb;
	logic hclk, hresetn, hwrite, uart_tx, lsb, hreadyout, hresp, irq, urx;
	logic ck_o, ck_oe, in_o, in_oe, so_o, so_oe, sdo, ck_w, si_w, so_w, tb_sck;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, rd, hrdata;
	logic [7:0] ptx, prx;
	int num_errors, total_checks, cycles;
	assign ck_w = ck_oe ? ck_o : tb_sck;
	assign si_w = in_oe ? in_o : sdo;
	assign so_w = so_oe ? so_o : 1'b1;
	three_wire_serial_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.serial_clock_pin_i(ck_w), .serial_clock_pin_o(ck_o), .serial_clock_pin_oe(ck_oe),
		.serial_in_pin_i(si_w), .serial_in_pin_o(in_o), .serial_in_pin_oe(in_oe),
		.serial_out_pin_i(so_w), .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe),
		.uart_transmit_pin(uart_tx), .uart_receive_pin(urx), .irq(irq));
	serial_peer peer_u (.rst_n(hresetn), .sck(ck_w), .sdi(so_w), .lsb(lsb),
		.tx_byte(ptx), .sdo(sdo), .rx_byte(prx));
	////////////////////////////////////////
	task stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// polls busy; a stuck transfer is left to the cycle ceiling
	task wait_idle;
		do bus(1'b0, `OFS_OP_MODE, 32'h0); while (rd[`POS_BUSY] !== 1'b0);
	endtask
	task xfer(input logic [7:0] mode, input logic [7:0] t, input logic [7:0] p);
		lsb = mode[`POS_BIT_ORDER];
		ptx = p;
		wr(`OFS_OP_MODE, {24'h0, mode});
		wr(`OFS_TX_BUFFER, {24'h0, t});
		wait_idle();
		chk({24'h0, prx}, {24'h0, t});
		rdc(`OFS_SHIFT, {24'h0, p});
	endtask
	////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		{hresetn, hwrite, uart_tx, lsb, htrans, haddr, hwdata, ptx} = '0;
		tb_sck = 1'b1;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(`OFS_CLOCK_SELECT, 32'h0);
		rdc(`OFS_PORT_MODE, 32'h7);
		rdc(`OFS_IRQ_MASK, 32'h0);
		rdc(8'h24, 32'h0);
		wr(`OFS_TX_BUFFER, 32'h33);
		rdc(`OFS_TX_BUFFER, 32'h33);
		rdc(`OFS_OP_MODE, 32'h0);
		rdc(`OFS_IRQ_STATUS, 32'h0);
		wr(`OFS_PORT_LATCH, 32'h1);
		wr(`OFS_PORT_MODE, 32'h2);
		@(negedge hclk);
		chk({25'h0, urx, hresp, in_o, ck_w, so_oe, in_oe, ck_oe}, 32'hd);
		rdc(`OFS_PIN_LEVEL, 32'h1);
		xfer(8'hc0, 8'ha5, 8'h3c);
		rdc(`OFS_IRQ_STATUS, 32'h1);
		wr(`OFS_IRQ_MASK, 32'h3);
		@(negedge hclk);
		chk({31'h0, irq}, 32'h1);
		wr(`OFS_IRQ_STATUS, 32'h1);
		@(negedge hclk);
		chk({31'h0, irq}, 32'h0);
		wr(`OFS_TX_BUFFER, 32'h11);
		wr(`OFS_TX_BUFFER, 32'h22);
		wait_idle();
		chk({24'h0, prx}, 32'h11);
		rdc(`OFS_IRQ_STATUS, 32'h3);
		wr(`OFS_IRQ_STATUS, 32'h3);
		xfer(8'hd0, 8'h01, 8'h12);
		// slave: the bench makes the clock, idle high, three hclk per half period
		wr(`OFS_CLOCK_SELECT, 32'h7);
		wr(`OFS_PORT_MODE, 32'h3);
		wr(`OFS_PORT_LATCH, 32'h0);
		lsb = 1'b0;
		ptx = 8'h96;
		wr(`OFS_OP_MODE, 32'hc0);
		wr(`OFS_TX_BUFFER, 32'h5a);
		repeat (16) begin
			repeat (3) @(posedge hclk);
			tb_sck <= ~tb_sck;
		end
		wait_idle();
		chk({24'h0, prx}, 32'h5a);
		rdc(`OFS_SHIFT, 32'h96);
		ptx = 8'h6b;
		uart_tx <= 1'b1;
		wr(`OFS_CLOCK_SELECT, 32'h0);
		wr(`OFS_PORT_LATCH, 32'h5);
		// direction last, so the peer never sees the clock latch low as an edge
		wr(`OFS_PORT_MODE, 32'h2);
		wr(`OFS_OP_MODE, 32'h80);
		rdc(`OFS_SHIFT, 32'h96);
		wait_idle();
		rdc(`OFS_SHIFT, 32'h6b);
		@(negedge hclk);
		chk({31'h0, so_o}, 32'h1);
		wr(`OFS_OP_MODE, 32'hc0);
		wr(`OFS_TX_BUFFER, 32'hff);
		wr(`OFS_OP_MODE, 32'h0);
		rdc(`OFS_OP_MODE, 32'h0);
		@(negedge hclk);
		chk({31'h0, ck_w}, 32'h1);
		stop_test();
	end
endmodule
